//--- common/vdqr_defs.svh
/*
 * Holds the offsets, field positions, reset values and sizes of the video DMA
 * interrupt and queue register slice.
 * Assumes it is included by bare name wherever these constants are needed.
 */
`ifndef VDQR_DEFS_SVH
`define VDQR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets (low address byte decoded)
// ----------------------------------------------------------------------------
`define VDQR_OFS_GATE      8'h08
`define VDQR_OFS_PEND      8'h0C
`define VDQR_OFS_ENABLE    8'h10
`define VDQR_OFS_PTR_PUSH  8'h1C
`define VDQR_OFS_SIZE_POP  8'h24

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define VDQR_BIT_GATE      0
`define VDQR_BIT_EOF       0
`define VDQR_BIT_PTR_FULL  1
`define VDQR_BIT_PTR_EMPTY 2
`define VDQR_BIT_SZ_FULL   3
`define VDQR_BIT_SZ_EMPTY  4
`define VDQR_NSRC          5
`define VDQR_DW            32
`define VDQR_AW            38
`define VDQR_PAD_W         6

// ----------------------------------------------------------------------------
// Reset values, sizes and bus answers
// ----------------------------------------------------------------------------
`define VDQR_RST_SRC       5'h00
`define VDQR_RST_WORD      32'h0000_0000
`define VDQR_PAD_ZERO      6'h00
`define VDQR_STRB_ALL      4'hF
`define VDQR_DEPTH         32
`define VDQR_PTR_W         5
`define VDQR_CNT_W         6
`define VDQR_RESP_OKAY     2'h0
`define VDQR_RESP_SLVERR   2'h2

`endif

//--- common/vdqr_pkg.sv
/*
 * Holds the types shared by the register slice and its queues.
 * Assumes the constants header is on the include path.
 */
`include "vdqr_defs.svh"

package vdqr_pkg;

    typedef logic [`VDQR_DW-1:0]   vdqr_word_type;
    typedef logic [`VDQR_NSRC-1:0] vdqr_src_type;

    typedef enum logic [2:0] {
        VDQR_SEL_NONE  = 3'h0,
        VDQR_SEL_GATE  = 3'h1,
        VDQR_SEL_PEND  = 3'h2,
        VDQR_SEL_EN    = 3'h3,
        VDQR_SEL_PTR   = 3'h4,
        VDQR_SEL_SIZE  = 3'h5
    } vdqr_sel_type;

endpackage : vdqr_pkg

//--- common/vdqr_queue_if.sv
/*
 * Holds the link between the register slice and one of its word queues.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface vdqr_queue_if;
    import vdqr_pkg::*;

    logic          push;
    vdqr_word_type push_data;
    logic          pop;
    vdqr_word_type head;
    logic          full;
    logic          empty;

    modport owner (output push, push_data, pop, input head, full, empty);
    modport store (input push, push_data, pop, output head, full, empty);
endinterface : vdqr_queue_if

//--- hw/vdqr_queue.sv
/*
 * Holds a fixed 32-deep, 32-bit first-in first-out word queue.
 * Assumes push and pop come from logic on the same clock; a push into a full
 * queue and a pop from an empty one are ignored.
 */
`timescale 1ns/1ps
`include "vdqr_defs.svh"

module vdqr_queue
    import vdqr_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   arst_n_i,
    input  wire logic   ce_i,
    vdqr_queue_if.store q
);

    vdqr_word_type          mem [0:`VDQR_DEPTH-1];
    logic [`VDQR_PTR_W-1:0] wr_ptr;
    logic [`VDQR_PTR_W-1:0] rd_ptr;
    logic [`VDQR_CNT_W-1:0] count;
    logic                   do_push;
    logic                   do_pop;

    assign do_push = ce_i && q.push && (count != `VDQR_CNT_W'(`VDQR_DEPTH));
    assign do_pop  = ce_i && q.pop && (count != '0);
    assign q.full  = (count == `VDQR_CNT_W'(`VDQR_DEPTH));
    assign q.empty = (count == '0);
    assign q.head  = mem[rd_ptr];

    // Storage is left without reset; head reads mem[rd_ptr] even while the queue is empty
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= q.push_data;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + `VDQR_PTR_W'(1);
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + `VDQR_PTR_W'(1);
            end
            if (do_push && !do_pop) begin
                count <= count + `VDQR_CNT_W'(1);
            end else if (do_pop && !do_push) begin
                count <= count - `VDQR_CNT_W'(1);
            end
        end
    end

    chk_depth_cap : assert property (@(posedge clk_i) disable iff (!arst_n_i)
        count <= `VDQR_CNT_W'(`VDQR_DEPTH)) else $error("queue count over depth");
    chk_full_refuse : assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.full && q.push && !q.pop) |=> q.full && $stable(wr_ptr)) else $error("push taken while full");

endmodule : vdqr_queue

//--- hw/vdqr_regs.sv
/*
 * Holds the interrupt gate, pending and enable registers of a video frame
 * write DMA, its destination pointer queue and its written frame size queue,
 * reached over an AXI4-Lite slave port.
 * Assumes the frame datapath shares clk_i: it pops pointers, pulses
 * frame_done_i with the frame size, and all of it freezes while ce_i is low.
 */
`timescale 1ns/1ps
`include "vdqr_defs.svh"

module vdqr_regs
    import vdqr_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  ce_i,
    input  wire logic [31:0]           s_axi_awaddr_i,
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [31:0]           s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    output logic [1:0]                 s_axi_bresp_o,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    input  wire logic [31:0]           s_axi_araddr_i,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    output logic [31:0]                s_axi_rdata_o,
    output logic [1:0]                 s_axi_rresp_o,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i,
    input  wire logic                  ptr_pop_i,
    output logic                       ptr_valid_o,
    output logic [`VDQR_AW-1:0]        ptr_addr_o,
    output logic                       ptr_full_o,
    input  wire logic                  frame_done_i,
    input  wire logic [`VDQR_DW-1:0]   frame_size_i,
    output logic                       size_full_o,
    output logic                       irq_o
);

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function automatic vdqr_sel_type reg_sel(input logic [31:0] addr);
        unique case (addr[7:0])
            `VDQR_OFS_GATE:     reg_sel = VDQR_SEL_GATE;
            `VDQR_OFS_PEND:     reg_sel = VDQR_SEL_PEND;
            `VDQR_OFS_ENABLE:   reg_sel = VDQR_SEL_EN;
            `VDQR_OFS_PTR_PUSH: reg_sel = VDQR_SEL_PTR;
            `VDQR_OFS_SIZE_POP: reg_sel = VDQR_SEL_SIZE;
            default:            reg_sel = VDQR_SEL_NONE;
        endcase
    endfunction : reg_sel

    vdqr_queue_if ptr_q ();
    vdqr_queue_if size_q ();

    logic          gate;
    vdqr_src_type  pending;
    vdqr_src_type  enable;
    logic          ptr_empty_d;
    logic          ptr_full_d;
    logic          size_empty_d;
    logic          size_full_d;
    vdqr_sel_type  wr_sel;
    vdqr_sel_type  rd_sel;
    logic          wr_fire;
    logic          rd_fire;
    vdqr_src_type  events;
    vdqr_src_type  next_pending;
    logic          next_gate;
    vdqr_src_type  next_enable;

    assign wr_sel  = reg_sel(s_axi_awaddr_i);
    assign rd_sel  = reg_sel(s_axi_araddr_i);

    // ------------------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------------------
    // Address and data are taken together, so one write is in flight at a time
    assign wr_fire         = ce_i && s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
    assign s_axi_awready_o = wr_fire;
    assign s_axi_wready_o  = wr_fire;
    assign rd_fire         = ce_i && s_axi_arvalid_i && !s_axi_rvalid_o;
    assign s_axi_arready_o = ce_i && !s_axi_rvalid_o;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `VDQR_RESP_OKAY;
        end else if (ce_i) begin
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= (wr_sel == VDQR_SEL_NONE) ? `VDQR_RESP_SLVERR : `VDQR_RESP_OKAY;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o  <= `VDQR_RESP_OKAY;
            s_axi_rdata_o  <= `VDQR_RST_WORD;
        end else if (ce_i) begin
            if (rd_fire) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o  <= (rd_sel == VDQR_SEL_NONE) ? `VDQR_RESP_SLVERR : `VDQR_RESP_OKAY;
                unique case (rd_sel)
                    VDQR_SEL_GATE: s_axi_rdata_o <= {31'h0000_0000, gate};
                    VDQR_SEL_PEND: s_axi_rdata_o <= {27'h000_0000, pending};
                    VDQR_SEL_EN:   s_axi_rdata_o <= {27'h000_0000, enable};
                    // Empty queue reads as zero rather than stale storage
                    VDQR_SEL_SIZE: s_axi_rdata_o <= size_q.empty ? `VDQR_RST_WORD : size_q.head;
                    VDQR_SEL_PTR,
                    VDQR_SEL_NONE: s_axi_rdata_o <= `VDQR_RST_WORD;
                endcase
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Queues
    // ------------------------------------------------------------------------
    // Partial-strobe writes would enqueue a torn pointer, so they are dropped
    assign ptr_q.push      = wr_fire && (wr_sel == VDQR_SEL_PTR) && (s_axi_wstrb_i == `VDQR_STRB_ALL);
    assign ptr_q.push_data = s_axi_wdata_i;
    assign ptr_q.pop       = ptr_pop_i;
    assign ptr_valid_o     = !ptr_q.empty;
    assign ptr_addr_o      = {ptr_q.head, `VDQR_PAD_ZERO};
    assign ptr_full_o      = ptr_q.full;

    // A frame finishing into a full size queue loses its size entry
    assign size_q.push      = frame_done_i;
    assign size_q.push_data = frame_size_i;
    assign size_q.pop       = rd_fire && (rd_sel == VDQR_SEL_SIZE);
    assign size_full_o      = size_q.full;

    vdqr_queue u_ptr_queue (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .q        (ptr_q.store)
    );

    vdqr_queue u_size_queue (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .q        (size_q.store)
    );

    // ------------------------------------------------------------------------
    // Interrupt events and flags
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr_empty_d  <= 1'b1;
            ptr_full_d   <= 1'b0;
            size_empty_d <= 1'b1;
            size_full_d  <= 1'b0;
        end else if (ce_i) begin
            ptr_empty_d  <= ptr_q.empty;
            ptr_full_d   <= ptr_q.full;
            size_empty_d <= size_q.empty;
            size_full_d  <= size_q.full;
        end
    end

    always_comb begin
        events                      = '0;
        events[`VDQR_BIT_EOF]       = frame_done_i;
        events[`VDQR_BIT_PTR_FULL]  = ptr_q.full && !ptr_full_d;
        events[`VDQR_BIT_PTR_EMPTY] = ptr_q.empty && !ptr_empty_d;
        events[`VDQR_BIT_SZ_FULL]   = size_q.full && !size_full_d;
        events[`VDQR_BIT_SZ_EMPTY]  = size_q.empty && !size_empty_d;
    end

    always_comb begin
        next_gate    = gate;
        next_enable  = enable;
        next_pending = pending;
        if (wr_fire && s_axi_wstrb_i[0]) begin
            if (wr_sel == VDQR_SEL_GATE) begin
                next_gate = s_axi_wdata_i[`VDQR_BIT_GATE];
            end
            if (wr_sel == VDQR_SEL_EN) begin
                next_enable = s_axi_wdata_i[`VDQR_NSRC-1:0];
            end
            if (wr_sel == VDQR_SEL_PEND) begin
                // Upper sources clear on one, frame-done clears on zero
                next_pending[`VDQR_NSRC-1:1] = pending[`VDQR_NSRC-1:1]
                                             & ~s_axi_wdata_i[`VDQR_NSRC-1:1];
                if (!s_axi_wdata_i[`VDQR_BIT_EOF]) begin
                    next_pending[`VDQR_BIT_EOF] = 1'b0;
                end
            end
        end
        // Set after clear, so an event during a clear is never lost
        next_pending = next_pending | (events & enable);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gate    <= 1'b0;
            enable  <= `VDQR_RST_SRC;
            pending <= `VDQR_RST_SRC;
            irq_o   <= 1'b0;
        end else if (ce_i) begin
            gate    <= next_gate;
            enable  <= next_enable;
            pending <= next_pending;
            irq_o   <= next_gate && |(next_pending & next_enable);
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_gate_blocks_irq : assert property (!gate |-> !irq_o)
        else $error("interrupt raised while gate clear");
    chk_irq_merge : assert property (irq_o == (gate && |(pending & enable)))
        else $error("interrupt differs from gated merge");
    chk_sz_empty_set : assert property (ce_i && size_q.empty && !size_empty_d && enable[`VDQR_BIT_SZ_EMPTY]
        |=> pending[`VDQR_BIT_SZ_EMPTY])
        else $error("size empty flag not set");
    chk_sz_full_set : assert property (ce_i && $rose(size_q.full) && enable[`VDQR_BIT_SZ_FULL]
        |=> pending[`VDQR_BIT_SZ_FULL])
        else $error("size full flag not set");
    chk_ptr_empty_set : assert property (ce_i && ptr_q.empty && !ptr_empty_d && enable[`VDQR_BIT_PTR_EMPTY]
        |=> pending[`VDQR_BIT_PTR_EMPTY])
        else $error("pointer empty flag not set");
    chk_ptr_full_set : assert property (ce_i && ptr_q.full && !ptr_full_d && enable[`VDQR_BIT_PTR_FULL]
        |=> pending[`VDQR_BIT_PTR_FULL])
        else $error("pointer full flag not set");
    chk_eof_set : assert property (ce_i && frame_done_i && enable[`VDQR_BIT_EOF]
        |=> pending[`VDQR_BIT_EOF] ##1 (pending[`VDQR_BIT_EOF] || $past(wr_fire)))
        else $error("frame done flag not set or lost");
    chk_eof_clear : assert property (wr_fire && wr_sel == VDQR_SEL_PEND && s_axi_wstrb_i[0]
        && !s_axi_wdata_i[`VDQR_BIT_EOF] && !frame_done_i |=> !pending[`VDQR_BIT_EOF])
        else $error("frame done flag not cleared by zero");
    chk_ptr_pad : assert property (ptr_valid_o |-> ptr_addr_o[`VDQR_PAD_W-1:0] == `VDQR_PAD_ZERO
        && ptr_addr_o[`VDQR_AW-1:`VDQR_PAD_W] == ptr_q.head)
        else $error("pointer address misformed");
    chk_size_read : assert property (rd_fire && rd_sel == VDQR_SEL_SIZE && !size_q.empty && !size_q.push
        |=> s_axi_rvalid_o && s_axi_rdata_o == $past(size_q.head) && !size_q.full)
        else $error("size read did not return head");

    // Register loads, holds and freeze
    chk_gate_load : assert property (wr_fire && wr_sel == VDQR_SEL_GATE && s_axi_wstrb_i[0]
        |=> gate == $past(s_axi_wdata_i[`VDQR_BIT_GATE]))
        else $error("gate write not loaded");
    chk_enable_load : assert property (wr_fire && wr_sel == VDQR_SEL_EN && s_axi_wstrb_i[0]
        |=> enable == $past(s_axi_wdata_i[`VDQR_NSRC-1:0]))
        else $error("enable write not loaded");
    chk_upper_clear : assert property (wr_fire && wr_sel == VDQR_SEL_PEND && s_axi_wstrb_i[0]
        && !(|(events & enable)) |=> (pending[`VDQR_NSRC-1:1] & $past(s_axi_wdata_i[`VDQR_NSRC-1:1])) == '0)
        else $error("written one did not clear flag");
    chk_eof_keep : assert property (wr_fire && wr_sel == VDQR_SEL_PEND && s_axi_wstrb_i[0]
        && s_axi_wdata_i[`VDQR_BIT_EOF] && pending[`VDQR_BIT_EOF] |=> pending[`VDQR_BIT_EOF])
        else $error("frame done flag lost on written one");
    chk_ptr_push_take : assert property (wr_fire && wr_sel == VDQR_SEL_PTR && !ptr_q.full
        && s_axi_wstrb_i == `VDQR_STRB_ALL |=> ptr_valid_o)
        else $error("pointer write not queued");
    chk_ptr_torn_drop : assert property (wr_fire && wr_sel == VDQR_SEL_PTR && ptr_q.empty
        && s_axi_wstrb_i != `VDQR_STRB_ALL |=> !ptr_valid_o)
        else $error("partial pointer write queued");
    chk_one_write : assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while response pending");
    chk_irq_holds : assert property (irq_o && !(wr_fire && (wr_sel == VDQR_SEL_PEND
        || wr_sel == VDQR_SEL_GATE || wr_sel == VDQR_SEL_EN)) |=> irq_o)
        else $error("interrupt dropped without a clear");
    chk_ce_freeze : assert property (!ce_i |=> $stable(pending) && $stable(enable) && $stable(gate)
        && $stable(irq_o))
        else $error("state moved while clock enable low");

endmodule : vdqr_regs

//--- tb/test_video_dma_irq_and_queue_regs.sv
/*
 * Self-checking bench for the video DMA interrupt and queue register slice.
 * Assumes the constants header is on the include path and that the package
 * is compiled first; the bench plays both the processor and the datapath.
 */
`timescale 1ns/1ps
`include "vdqr_defs.svh"

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module test_video_dma_irq_and_queue_regs;
    import vdqr_pkg::*;

    logic          clk_i = 1'b0;
    logic          arst_n_i = 1'b0;
    logic          ce_i = 1'b0;
    logic [31:0]   awaddr = '0, wdata = '0, araddr = '0;
    logic [3:0]    wstrb = '0;
    logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic          awready, wready, bvalid, arready, rvalid;
    logic [1:0]    bresp, rresp;
    logic [31:0]   rdata;
    logic          ptr_pop_i = 0, frame_done_i = 0;
    logic [31:0]   frame_size_i = '0;
    logic          ptr_valid_o, ptr_full_o, size_full_o, irq_o;
    logic [37:0]   ptr_addr_o;
    logic [31:0]   d;
    int            errors = 0;
    int            comparisons = 0;
    int            cycles = 0;

    vdqr_regs i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .ptr_pop_i(ptr_pop_i), .ptr_valid_o(ptr_valid_o), .ptr_addr_o(ptr_addr_o), .ptr_full_o(ptr_full_o),
        .frame_done_i(frame_done_i), .frame_size_i(frame_size_i), .size_full_o(size_full_o), .irq_o(irq_o));

    always #20 clk_i = ~clk_i;

    // ------------------------------------------------------------------------
    // Bus and datapath helpers
    // ------------------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // Ready is combinational, so it is read before the edge's own updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] er);
        int n;
        @(posedge clk_i);
        awaddr <= {24'h00_0000, a};
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (!(awready && wready) && n < 20);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (!bvalid && n < 20);
        `CHK(bresp, er)
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge clk_i);
        araddr <= {24'h00_0000, a};
        arvalid <= 1'b1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (!arready && n < 20);
        arvalid <= 1'b0;
        rready <= 1'b1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (!rvalid && n < 20);
        v = rdata;
        `CHK(rresp, er)
        rready <= 1'b0;
    endtask : rd

    task automatic frame(input logic [31:0] sz);
        @(posedge clk_i);
        frame_done_i <= 1'b1;
        frame_size_i <= sz;
        @(posedge clk_i);
        frame_done_i <= 1'b0;
    endtask : frame

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        rd(`VDQR_OFS_GATE, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        rd(`VDQR_OFS_ENABLE, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        rd(`VDQR_OFS_SIZE_POP, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        rd(`VDQR_OFS_PTR_PUSH, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        rd(8'h40, d, `VDQR_RESP_SLVERR); `CHK(d, 32'h0000_0000)
        wr(8'h40, 32'hFFFF_FFFF, 4'hF, `VDQR_RESP_SLVERR);
        wr(`VDQR_OFS_ENABLE, 32'hFFFF_FFFF, 4'hF, `VDQR_RESP_OKAY);
        rd(`VDQR_OFS_ENABLE, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_001F)
        wr(`VDQR_OFS_ENABLE, 32'h0000_0000, 4'hF, `VDQR_RESP_OKAY);
        `CHK(irq_o, 1'b0)
        $display("test reset done");
    endtask : t_reset

    task automatic t_frame_irq;
        wr(`VDQR_OFS_ENABLE, 32'h0000_0001, 4'hF, `VDQR_RESP_OKAY);
        frame(32'h0000_1234);
        idle(3);
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0001)
        `CHK(irq_o, 1'b0)
        wr(`VDQR_OFS_GATE, 32'h0000_0001, 4'hF, `VDQR_RESP_OKAY);
        idle(2);
        `CHK(irq_o, 1'b1)
        wr(`VDQR_OFS_PEND, 32'h0000_0001, 4'hF, `VDQR_RESP_OKAY);
        idle(2);
        `CHK(irq_o, 1'b1)
        wr(`VDQR_OFS_PEND, 32'h0000_0000, 4'hF, `VDQR_RESP_OKAY);
        idle(2);
        `CHK(irq_o, 1'b0)
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        // A new frame lands on the very edge that takes the clear
        wr(`VDQR_OFS_PEND, 32'h0000_0001, 4'hF, `VDQR_RESP_OKAY);
        frame(32'h0000_5678);
        idle(2);
        fork
            wr(`VDQR_OFS_PEND, 32'h0000_0000, 4'hF, `VDQR_RESP_OKAY);
            frame(32'h0000_9ABC);
        join
        idle(2);
        `CHK(irq_o, 1'b1)
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0001)
        wr(`VDQR_OFS_ENABLE, 32'h0000_0010, 4'hF, `VDQR_RESP_OKAY);
        wr(`VDQR_OFS_PEND, 32'h0000_0000, 4'hF, `VDQR_RESP_OKAY);
        rd(`VDQR_OFS_SIZE_POP, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_1234)
        rd(`VDQR_OFS_SIZE_POP, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_5678)
        rd(`VDQR_OFS_SIZE_POP, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_9ABC)
        idle(2);
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0010)
        `CHK(irq_o, 1'b1)
        wr(`VDQR_OFS_PEND, 32'h0000_0010, 4'hF, `VDQR_RESP_OKAY);
        idle(2);
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        `CHK(irq_o, 1'b0)
        rd(`VDQR_OFS_SIZE_POP, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        $display("test frame irq done");
    endtask : t_frame_irq

    task automatic t_pointers;
        wr(`VDQR_OFS_ENABLE, 32'h0000_0006, 4'hF, `VDQR_RESP_OKAY);
        wr(`VDQR_OFS_PTR_PUSH, 32'h1111_1111, 4'h3, `VDQR_RESP_OKAY);
        idle(1);
        `CHK(ptr_valid_o, 1'b0)
        for (int i = 0; i < `VDQR_DEPTH; i++)
            wr(`VDQR_OFS_PTR_PUSH, 32'hC000_0000 | i, 4'hF, `VDQR_RESP_OKAY);
        idle(2);
        `CHK(ptr_full_o, 1'b1)
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0002)
        wr(`VDQR_OFS_PTR_PUSH, 32'hDEAD_BEEF, 4'hF, `VDQR_RESP_OKAY);
        for (int i = 0; i < `VDQR_DEPTH; i++) begin
            idle(1);
            `CHK(ptr_valid_o, 1'b1)
            `CHK(ptr_addr_o, {32'hC000_0000 | i, 6'h00})
            @(posedge clk_i);
            ptr_pop_i <= 1'b1;
            @(posedge clk_i);
            ptr_pop_i <= 1'b0;
        end
        idle(2);
        `CHK(ptr_valid_o, 1'b0)
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0006)
        wr(`VDQR_OFS_PEND, 32'h0000_0006, 4'hF, `VDQR_RESP_OKAY);
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        $display("test pointers done");
    endtask : t_pointers

    task automatic t_size_full;
        wr(`VDQR_OFS_ENABLE, 32'h0000_0008, 4'hF, `VDQR_RESP_OKAY);
        for (int i = 0; i <= `VDQR_DEPTH; i++)
            frame(32'h0000_0100 + i);
        idle(2);
        `CHK(size_full_o, 1'b1)
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0008)
        wr(`VDQR_OFS_PEND, 32'h0000_0008, 4'hF, `VDQR_RESP_OKAY);
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        for (int i = 0; i < `VDQR_DEPTH; i++) begin
            rd(`VDQR_OFS_SIZE_POP, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0100 + i)
        end
        idle(2);
        `CHK(size_full_o, 1'b0)
        rd(`VDQR_OFS_PEND, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        // Clock enable low: a frame pulse must leave no size entry behind
        @(posedge clk_i);
        ce_i <= 1'b0;
        frame(32'h0000_0777);
        ce_i <= 1'b1;
        rd(`VDQR_OFS_SIZE_POP, d, `VDQR_RESP_OKAY); `CHK(d, 32'h0000_0000)
        $display("test size full done");
    endtask : t_size_full

    // ------------------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        ce_i <= 1'b1;
        t_reset();
        t_frame_irq();
        t_pointers();
        t_size_full();
        end_sim();
    end

endmodule : test_video_dma_irq_and_queue_regs
